/* File: gpp_ext.sv */
// model of the circuitry outside the port pins
`timescale 1ns/1ps
module gpp_ext (
  // clock
  input wire logic aclk,
  // pins from the port
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  // outside drive
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_i
);
  logic [7:0] last = 8'h00;
  // port driver, then outside driver, then pull-up; a floating line flips
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | ~last));
  always_ff @(posedge aclk) begin
    last <= pin_i;
  end
endmodule

/* File: gpp_pkg.sv */
// package for the gpio pin port block
package gpp_pkg;
  localparam int GPP_NPINS = 8;
  // register byte offsets
  localparam logic [3:0] GPP_OFF_OUT = 4'h0;
  localparam logic [3:0] GPP_OFF_DIR = 4'h4;
  localparam logic [3:0] GPP_OFF_PIN = 4'h8;
  localparam logic [3:0] GPP_OFF_CTL = 4'hc;
  // processor control register fields, port reset value and bus response codes
  localparam int GPP_CTL_PUD_BIT = 6;
  localparam int GPP_CTL_SLEEP_BIT = 0;
  localparam logic [7:0] GPP_RST_PORT = 8'h00;
  localparam logic [1:0] GPP_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] outv;
    logic global_pullup_disable;
    logic deep_sleep;
  } gpp_cfg_s;

  typedef struct packed {
    logic [7:0] pullup_override_enable;
    logic [7:0] pullup_override_value;
    logic [7:0] wake_en;
  } gpp_alt_s;
endpackage

/* File: gpp_port.sv */
// gpio pin port with axi4-lite registers
`timescale 1ns/1ps
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - output data and direction read-write; input pins location read-only.
// - single-bit changes leave every other pin untouched.
// - global pull-up disable turns off every pull-up not under override.
// - direction one makes an output, zero an input.
// - without override, input with value one has pull-up; off when zero or output.
// - without override, pull-up only for dir 0, value 1, disable 0.
// - output drives high for value one, low for zero.
// - pins tri-state immediately on reset, without clock.
// - input bit shows pin level whatever the direction.
// - latch open while clock high, then registered at rising edge.
// - written value appears in input bit one clock later.
// - deep sleep disables input buffers except wake-up pins.
// - alternate functions on some pins leave other pins intact.
// - pull-up disable is bit 6 of control register, overriding.
// - override enable makes pull-up follow override value.
// - interrupt-enabled pins keep input buffer in sleep.
module gpp_port
  import gpp_pkg::*;
#(
  parameter int NPINS = GPP_NPINS
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // alternate function overrides
  input wire gpp_alt_s alt,
  // pins
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pin_pullup
);
  typedef struct packed {
    gpp_cfg_s cfg;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gpp_state_s;

  gpp_state_s st;
  gpp_state_s next_st;
  logic [7:0] pin_sync;
  logic [7:0] pin_in;
  logic [7:0] in_en;

  if (NPINS != 8) begin : g_bad_npins
    $error("pin count must be 8");
  end

  function automatic logic [31:0] read_reg(input logic [3:0] a, input gpp_cfg_s c,
                                           input logic [7:0] p);
    logic [31:0] r;
    r = '0;
    case (a)
      GPP_OFF_OUT: r[7:0] = c.outv;
      GPP_OFF_DIR: r[7:0] = c.dir;
      GPP_OFF_PIN: r[7:0] = p;
      GPP_OFF_CTL: begin
        r[GPP_CTL_PUD_BIT] = c.global_pullup_disable;
        r[GPP_CTL_SLEEP_BIT] = c.deep_sleep;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  //------------------------------------------------------------
  // pin drive
  //------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      pin_oe[i] = aresetn & st.cfg.dir[i];
      pin_o[i] = aresetn & st.cfg.dir[i] & st.cfg.outv[i];
      if (!aresetn) begin
        pin_pullup[i] = 1'b0;
      end else if (alt.pullup_override_enable[i]) begin
        pin_pullup[i] = alt.pullup_override_value[i];
      end else begin
        pin_pullup[i] = ~st.cfg.dir[i] & st.cfg.outv[i] & ~st.cfg.global_pullup_disable;
      end
      in_en[i] = ~st.cfg.deep_sleep | alt.wake_en[i];
    end
  end

  assign pin_in = pin_i & in_en;
  gpp_sync #(.WIDTH(NPINS)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d(pin_in),
    .q(pin_sync)
  );

  //------------------------------------------------------------
  // bus slave
  //------------------------------------------------------------
  // ce low stalls every handshake
  assign s_awready = ce & ~st.aw_got & ~st.bvalid;
  assign s_wready = ce & ~st.w_got & ~st.bvalid;
  assign s_arready = ce & ~st.rvalid;
  assign s_bvalid = ce & st.bvalid;
  assign s_bresp = st.bresp;
  assign s_rvalid = ce & st.rvalid;
  assign s_rdata = st.rdata;
  assign s_rresp = st.rresp;

  always_comb begin
    logic aw_now;
    logic w_now;
    aw_now = 1'b0;
    w_now = 1'b0;
    next_st = st;
    if (s_awvalid && s_awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_wdata;
      next_st.w_strb = s_wstrb;
    end
    aw_now = next_st.aw_got;
    w_now = next_st.w_got;
    if (st.bvalid && s_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (aw_now && w_now && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = GPP_RESP_OKAY;
      if (next_st.w_strb[0]) begin
        case ({next_st.aw_addr[3:2], 2'b00})
          GPP_OFF_OUT: next_st.cfg.outv = next_st.w_data[7:0];
          GPP_OFF_DIR: next_st.cfg.dir = next_st.w_data[7:0];
          GPP_OFF_CTL: begin
            next_st.cfg.global_pullup_disable = next_st.w_data[GPP_CTL_PUD_BIT];
            next_st.cfg.deep_sleep = next_st.w_data[GPP_CTL_SLEEP_BIT];
          end
          GPP_OFF_PIN: next_st.bresp = GPP_RESP_SLVERR;
          default: next_st.bresp = GPP_RESP_SLVERR;
        endcase
      end
    end
    if (st.rvalid && s_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = read_reg({s_araddr[3:2], 2'b00}, st.cfg, pin_sync);
      next_st.rresp = GPP_RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.cfg.dir <= GPP_RST_PORT;
      st.cfg.outv <= GPP_RST_PORT;
    end else if (ce) begin
      st <= next_st;
    end
  end

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  property p_reset_tristate;
    @(posedge aclk) !aresetn |-> (pin_oe == '0 && pin_pullup == '0);
  endproperty
  a_reset_tristate: assert property (p_reset_tristate) else $error("pins not tristate");

  property p_dir_drive;
    @(posedge aclk) disable iff (!aresetn) pin_oe == st.cfg.dir;
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("enable not direction");

  property p_out_level;
    @(posedge aclk) disable iff (!aresetn) (pin_o & pin_oe) == (st.cfg.outv & st.cfg.dir);
  endproperty
  a_out_level: assert property (p_out_level) else $error("output level wrong");

  property p_pud_off;
    @(posedge aclk) disable iff (!aresetn) st.cfg.global_pullup_disable |-> (pin_pullup & ~alt.pullup_override_enable) == '0;
  endproperty
  a_pud_off: assert property (p_pud_off) else $error("pullup despite disable");

  property p_pullup_cond;
    @(posedge aclk) disable iff (!aresetn)
      (pin_pullup & ~alt.pullup_override_enable) == (~st.cfg.dir & st.cfg.outv & {8{~st.cfg.global_pullup_disable}} & ~alt.pullup_override_enable);
  endproperty
  a_pullup_cond: assert property (p_pullup_cond) else $error("pullup condition wrong");

  property p_override;
    @(posedge aclk) disable iff (!aresetn) (pin_pullup & alt.pullup_override_enable) == (alt.pullup_override_value & alt.pullup_override_enable);
  endproperty
  a_override: assert property (p_override) else $error("override not followed");

  property p_sync_delay;
    @(posedge aclk) disable iff (!aresetn) ce |=> pin_sync == $past(pin_in);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

  property p_dir_write;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !st.bvalid && next_st.bvalid && next_st.w_strb[0]
       && next_st.aw_addr[3:2] == GPP_OFF_DIR[3:2]) |=> st.cfg.dir == $past(next_st.w_data[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_rst_zero;
    @(posedge aclk) !aresetn |=> (st.cfg.dir == '0 && st.cfg.outv == '0);
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("reset values wrong");

  property p_out_write;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !st.bvalid && next_st.bvalid && next_st.w_strb[0]
       && next_st.aw_addr[3:2] == GPP_OFF_OUT[3:2])
      |=> st.cfg.outv == $past(next_st.w_data[7:0]);
  endproperty
  a_out_write: assert property (p_out_write) else $error("output write lost");

  property p_ctl_write;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !st.bvalid && next_st.bvalid && next_st.w_strb[0]
       && next_st.aw_addr[3:2] == GPP_OFF_CTL[3:2])
      |=> st.cfg.global_pullup_disable == $past(next_st.w_data[GPP_CTL_PUD_BIT]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("pull-up disable write lost");

  property p_pin_ro;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !st.bvalid && next_st.bvalid && next_st.w_strb[0]
       && next_st.aw_addr[3:2] == GPP_OFF_PIN[3:2])
      |=> $stable(st.cfg) && s_bresp == GPP_RESP_SLVERR;
  endproperty
  a_pin_ro: assert property (p_pin_ro) else $error("input location written");

  property p_strb_skip;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !st.bvalid && next_st.bvalid && !next_st.w_strb[0]) |=> $stable(st.cfg);
  endproperty
  a_strb_skip: assert property (p_strb_skip) else $error("masked write changed state");

  property p_pullup_off;
    @(posedge aclk) disable iff (!aresetn)
      (pin_pullup & ~alt.pullup_override_enable & (st.cfg.dir | ~st.cfg.outv)) == '0;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-up left on");

  property p_sleep_clamp;
    @(posedge aclk) disable iff (!aresetn) st.cfg.deep_sleep |-> (pin_in & ~alt.wake_en) == '0;
  endproperty
  a_sleep_clamp: assert property (p_sleep_clamp) else $error("input not clamped");

  property p_wake_pass;
    @(posedge aclk) disable iff (!aresetn) (pin_in & alt.wake_en) == (pin_i & alt.wake_en);
  endproperty
  a_wake_pass: assert property (p_wake_pass) else $error("wake-up pin clamped");

  property p_read_pins;
    @(posedge aclk) disable iff (!aresetn)
      (s_arvalid && s_arready && s_araddr[3:2] == GPP_OFF_PIN[3:2])
      |=> s_rdata[7:0] == $past(pin_sync);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("pin read not synchronized");

  property p_ce_stall;
    @(posedge aclk) disable iff (!aresetn)
      !ce |-> !(s_awready || s_wready || s_arready || s_bvalid || s_rvalid);
  endproperty
  a_ce_stall: assert property (p_ce_stall) else $error("handshake while frozen");

  c_write: cover property (@(posedge aclk) s_bvalid && s_bready);
  c_read: cover property (@(posedge aclk) s_rvalid && s_rready);
  c_pullup: cover property (@(posedge aclk) pin_pullup != '0);
  c_sleep: cover property (@(posedge aclk) st.cfg.deep_sleep && alt.wake_en != '0);
  c_slverr: cover property (@(posedge aclk) s_bvalid && s_bresp == GPP_RESP_SLVERR);
endmodule

/* File: gpp_sync.sv */
// pin input synchronizer: high-phase latch then rising-edge register
`timescale 1ns/1ps
module gpp_sync
  import gpp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] latch_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("width too small");
  end

  // latch transparent while clock high, holds while low
  always_latch begin
    if (aclk) begin
      latch_q = d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= latch_q;
    end
  end
endmodule

/* File: tb_top.sv */
// self-checking testbench for the gpio pin port
`timescale 1ns/1ps
module tb_top;
  import gpp_pkg::*;
  logic aclk, aresetn, ce, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [3:0] s_awaddr, s_araddr, s_wstrb;
  logic [31:0] s_wdata, s_rdata;
  logic [1:0] s_bresp, s_rresp;
  gpp_alt_s alt;
  logic [7:0] pin_i, pin_o, pin_oe, pin_pullup, ext_en, ext_val;
  int fails, checks_done, o, d, c, pu, lv, m;

  gpp_port uut (.aclk, .aresetn, .ce, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .alt, .pin_i, .pin_o, .pin_oe, .pin_pullup);
  gpp_ext ext (.aclk, .pin_o, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_i);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ----
  // check, finish and bus tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw_open;
    logic w_open;
    logic b_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    b_open = 1'b1;
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (int n = 0; n < 50 && b_open; n++) begin
      @(posedge aclk);
      if (aw_open && s_awready) begin
        aw_open = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w_open && s_wready) begin
        w_open = 1'b0;
        s_wvalid <= 1'b0;
      end
      if (s_bvalid) begin
        b_open = 1'b0;
        s_bready <= 1'b0;
        chk("bresp", er, s_bresp);
      end
    end
    if (b_open) begin
      fails++;
      stop_test();
    end
    @(posedge aclk);
  endtask

  task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [31:0] k,
                     input string nm);
    logic ar_open;
    logic r_open;
    ar_open = 1'b1;
    r_open = 1'b1;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (int n = 0; n < 50 && r_open; n++) begin
      @(posedge aclk);
      if (ar_open && s_arready) begin
        ar_open = 1'b0;
        s_arvalid <= 1'b0;
      end
      if (s_rvalid) begin
        r_open = 1'b0;
        s_rready <= 1'b0;
        chk(nm, e & k & 32'hff, s_rdata & k);
        chk("rresp", GPP_RESP_OKAY, s_rresp);
      end
    end
    if (r_open) begin
      fails++;
      stop_test();
    end
    @(posedge aclk);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h00;
    {s_awaddr, s_araddr, s_wdata, alt, ext_en, ext_val} = '0;
    ce = 1'b1;
    s_wstrb = 4'hf;
    fails = 0;
    checks_done = 0;
    void'($urandom(32'hb977));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(GPP_OFF_OUT, 0, 32'hffff, "out");
    axr(GPP_OFF_DIR, 0, 32'hffff, "dir");
    axw(GPP_OFF_PIN, 32'hff, GPP_RESP_SLVERR);
    for (int i = 0; i < 40; i++) begin
      o = $urandom & 32'hff;
      d = $urandom & 32'hff;
      c = $urandom & 32'h41;
      alt <= 24'($urandom);
      ext_val <= 8'($urandom);
      ext_en <= 8'($urandom) & ~8'(d);
      // value before direction keeps every pin on a legal path
      axw(GPP_OFF_OUT, o, GPP_RESP_OKAY);
      axw(GPP_OFF_DIR, d, GPP_RESP_OKAY);
      axw(GPP_OFF_CTL, c, GPP_RESP_OKAY);
      #1;
      pu = ((alt.pullup_override_enable & alt.pullup_override_value) | (~alt.pullup_override_enable & ~d & o & (c[6] ? 0 : 32'hff))) & 32'hff;
      chk("pin_oe", d, pin_oe);
      chk("pin_o", o & d, pin_o & pin_oe);
      chk("pin_pullup", pu, pin_pullup);
      lv = (d & o) | (~d & ext_en & ext_val) | (~d & ~ext_en & pu);
      m = d | ext_en | pu | (c[0] ? ~alt.wake_en : 0);
      axr(GPP_OFF_PIN, lv & (c[0] ? alt.wake_en : 32'hff), m, "pins");
      axr(GPP_OFF_OUT, o, 32'hffff, "out");
      axr(GPP_OFF_CTL, c, 32'hffff, "ctl");
    end
    s_wstrb <= 4'h0;
    axw(GPP_OFF_OUT, 32'h5a, GPP_RESP_OKAY);
    s_wstrb <= 4'hf;
    axr(GPP_OFF_OUT, o, 32'hffff, "out strb");
    axw(GPP_OFF_CTL, 0, GPP_RESP_OKAY);
    ce <= 1'b0;
    fork
      axw(GPP_OFF_DIR, 32'h0f, GPP_RESP_OKAY);
      begin
        repeat (3) @(posedge aclk);
        chk("pin_oe frozen", d & 32'hff, pin_oe);
        ce <= 1'b1;
      end
    join
    chk("pin_oe", 32'h0f, pin_oe);
    aresetn <= 1'b0;
    #1;
    chk("pin_oe rst", 0, pin_oe);
    chk("pin_pullup rst", 0, pin_pullup);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(GPP_OFF_DIR, 0, 32'hffff, "dir");
    axr(GPP_OFF_OUT, 0, 32'hffff, "out");
    stop_test();
  end
endmodule
